// File: design/obcl_cfg.svh
`ifndef OBCL_CFG_SVH
`define OBCL_CFG_SVH

// ----------------------------------------------------------------------------
// Option area addresses and byte count.
// ----------------------------------------------------------------------------
`define OBCL_ADDR_W 16
`define OBCL_PRIMARY_BASE 16'h0080
`define OBCL_MIRROR_BASE 16'h1080
`define OBCL_NUM_BYTES 3'h5
`define OBCL_IDX_W 3
`define OBCL_LAST_IDX 3'h4

// ----------------------------------------------------------------------------
// Byte indices within the option area.
// ----------------------------------------------------------------------------
`define OBCL_IDX_WDT 3'h0
`define OBCL_IDX_DET 3'h1
`define OBCL_IDX_RSV 3'h2
`define OBCL_IDX_DBGM 3'h3
`define OBCL_IDX_DBGS 3'h4

// ----------------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------------
`define OBCL_WDT_MUST_ZERO 7
`define OBCL_WDT_FRAC_HI 6
`define OBCL_WDT_FRAC_LO 5
`define OBCL_WDT_RUN 4
`define OBCL_WDT_PER_HI 3
`define OBCL_WDT_PER_LO 1
`define OBCL_WDT_LOCK 0
`define OBCL_DET_ON 0
`define OBCL_DBGM_CUT 4
`define OBCL_DBGM_FORCE 0
`define OBCL_DBGS_HI 1
`define OBCL_DBGS_LO 0

// ----------------------------------------------------------------------------
// Reset values and encodings.
// ----------------------------------------------------------------------------
`define OBCL_BYTE_RST 8'h00
`define OBCL_PER_BASE_LOG2 5'h0a
`define OBCL_FRAC_PROHIBIT 2'h0
`define OBCL_PER_PROHIBIT 3'h0
`define OBCL_DBG_PROHIBIT 2'h1

// ----------------------------------------------------------------------------
// Register read offsets of the latched bytes and status.
// ----------------------------------------------------------------------------
`define OBCL_REG_AW 8
`define OBCL_REG_WDT 8'h80
`define OBCL_REG_DET 8'h81
`define OBCL_REG_RSV 8'h82
`define OBCL_REG_DBGM 8'h83
`define OBCL_REG_DBGS 8'h84
`define OBCL_REG_STATUS 8'h90
`define OBCL_REG_RD_ZERO 8'h00

`endif

// File: design/obcl_pkg.sv
package obcl_pkg;

    typedef enum logic [1:0] {
        OBCL_FRAC_25,
        OBCL_FRAC_50,
        OBCL_FRAC_75,
        OBCL_FRAC_100
    } obcl_frac_t;

    typedef enum logic [1:0] {
        OBCL_DBG_OFF,
        OBCL_DBG_BAD,
        OBCL_DBG_KEEP,
        OBCL_DBG_ERASE
    } obcl_dbg_t;

    typedef struct packed {
        obcl_frac_t open_fraction;
        logic run_after_reset;
        logic [2:0] period_sel;
        logic [4:0] period_log2;
        logic slow_osc_lock;
    } obcl_wdt_cfg_t;

    typedef struct packed {
        logic debug_mode_force;
        logic debug_stop_clock_cut;
        obcl_dbg_t debug_ctrl;
        logic debug_enable;
        logic erase_on_auth_fail;
    } obcl_dbg_cfg_t;

    typedef struct packed {
        logic halt_or_stop;
        logic stop_mode;
        logic debug_active;
        logic slow_osc_stop_request;
        logic aux_timer_on_slow_osc;
    } obcl_run_state_t;

    typedef struct packed {
        logic slow_osc_enable;
        logic wdt_count_clk_en;
        logic aux_timer_clk_en;
        logic internal_osc_keep;
        logic debug_serial_clk_en;
    } obcl_clk_gate_t;

endpackage

// File: design/obcl_loader.sv
// The plain strobed port was decided locally.
`timescale 1ns/1ps
// Contract
// - Byte 0 bits 6:5 select watchdog open fraction 25, 50, 75 or 100 percent.
// - Byte 0 bit 4 set starts watchdog and illegal access detection after reset.
// - Byte 0 bits 3:1 select overflow of 2^10 to 2^17 slow clocks.
// - Byte 0 bit 0 set keeps slow oscillator running despite a stop request.
// - Lock clear withholds watchdog count clock in halt and stop.
// - Auxiliary timer on slow oscillator keeps its clock in halt and stop.
// - Watchdog keeps counting during flash self-programming.
// - Byte 1 bit 0 sets detector default start; bits 7:1 are zero.
// - Detector start bit only set by external programmer, never self-programming.
// - Changing detector start bit needs a full chip erase.
// - Byte 3 bit 4 clear keeps oscillator and debug port clock in stop; the code keeps them only while debug_active is set.
// - Byte 3 bit 0 forces on-chip debug mode when set.
// - Byte 4 bits 1:0 select debug off, prohibited, keep or erase on failure.
// - Boot swap fetches bytes from the mirror area instead of the primary.
// - Settings are read and applied during reset processing.
`include "obcl_cfg.svh"
module obcl_loader
    import obcl_pkg::*;
#(
    parameter int READ_LATENCY = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic boot_swap,
    output logic [`OBCL_ADDR_W-1:0] flash_addr,
    output logic flash_rd,
    input wire logic [7:0] flash_rdata,
    input wire obcl_run_state_t run_state,
    output obcl_wdt_cfg_t wdt_cfg,
    output logic detector_default_on,
    output obcl_dbg_cfg_t dbg_cfg,
    output obcl_clk_gate_t clk_gate,
    output logic cpu_reset_hold,
    output logic cfg_valid,
    output logic opt_bad,
    input wire logic [`OBCL_REG_AW-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata
);

    // ------------------------------------------------------------------------
    // Fetch sequencer.
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        OBCL_ST_START,
        OBCL_ST_ISSUE,
        OBCL_ST_WAIT,
        OBCL_ST_DONE
    } obcl_state_t;

    obcl_state_t state_r;
    obcl_state_t state_nxt;
    logic [`OBCL_IDX_W-1:0] idx_r;
    logic [`OBCL_IDX_W-1:0] idx_nxt;
    logic [7:0] wait_r;
    logic [7:0] wait_nxt;
    logic swap_r;
    logic swap_nxt;
    logic [7:0] opt_r [`OBCL_NUM_BYTES];
    logic [`OBCL_ADDR_W-1:0] base_addr;
    logic data_take;
    logic last_byte;

    // The area is chosen once, in the start cycle, so that a swap change half
    // way through the fetch cannot mix the two areas.
    assign swap_nxt = (state_r == OBCL_ST_START) ? boot_swap : swap_r;
    assign base_addr = swap_nxt ? `OBCL_MIRROR_BASE : `OBCL_PRIMARY_BASE;
    assign data_take = (state_r == OBCL_ST_WAIT) && (wait_r == 8'h00);
    assign last_byte = (idx_r == `OBCL_LAST_IDX);

    always_comb begin
        state_nxt = state_r;
        idx_nxt = idx_r;
        wait_nxt = wait_r;
        case (state_r)
            OBCL_ST_START: begin
                state_nxt = OBCL_ST_ISSUE;
            end
            OBCL_ST_ISSUE: begin
                state_nxt = OBCL_ST_WAIT;
                wait_nxt = 8'(READ_LATENCY - 1);
            end
            OBCL_ST_WAIT: begin
                if (wait_r != 8'h00) begin
                    wait_nxt = wait_r - 8'h01;
                end else if (last_byte) begin
                    state_nxt = OBCL_ST_DONE;
                end else begin
                    idx_nxt = idx_r + `OBCL_IDX_W'(1);
                    state_nxt = OBCL_ST_ISSUE;
                end
            end
            OBCL_ST_DONE: begin
                state_nxt = OBCL_ST_DONE;
            end
            default: begin
                state_nxt = OBCL_ST_START;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= OBCL_ST_START;
            idx_r <= `OBCL_IDX_WDT;
            wait_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            idx_r <= idx_nxt;
            wait_r <= wait_nxt;
        end
    end

    // Boot swap is caught in the start cycle after reset release.
    always_ff @(posedge clk) begin
        if (rst) begin
            swap_r <= 1'b0;
        end else begin
            swap_r <= swap_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            flash_addr <= `OBCL_PRIMARY_BASE;
            flash_rd <= 1'b0;
        end else begin
            flash_addr <= base_addr + `OBCL_ADDR_W'(idx_nxt);
            flash_rd <= (state_nxt == OBCL_ST_ISSUE);
        end
    end

    // ------------------------------------------------------------------------
    // Option byte store, written only during the fetch.
    // ------------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `OBCL_NUM_BYTES; gi++) begin : g_opt
            always_ff @(posedge clk) begin
                if (rst) begin
                    opt_r[gi] <= `OBCL_BYTE_RST;
                end else if (data_take && idx_r == `OBCL_IDX_W'(gi)) begin
                    opt_r[gi] <= flash_rdata;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Field decode.
    // ------------------------------------------------------------------------
    obcl_wdt_cfg_t wdt_dec;
    obcl_dbg_cfg_t dbg_dec;
    obcl_clk_gate_t gate_dec;
    logic [1:0] frac_code;
    logic [2:0] per_code;
    logic [1:0] dbg_code;
    logic bad_dec;
    logic done;

    assign done = (state_r == OBCL_ST_DONE);
    assign frac_code = opt_r[`OBCL_IDX_WDT][`OBCL_WDT_FRAC_HI:`OBCL_WDT_FRAC_LO];
    assign per_code = opt_r[`OBCL_IDX_WDT][`OBCL_WDT_PER_HI:`OBCL_WDT_PER_LO];
    assign dbg_code = opt_r[`OBCL_IDX_DBGS][`OBCL_DBGS_HI:`OBCL_DBGS_LO];

    assign wdt_dec.open_fraction = obcl_frac_t'(frac_code);
    assign wdt_dec.run_after_reset = opt_r[`OBCL_IDX_WDT][`OBCL_WDT_RUN];
    assign wdt_dec.period_sel = per_code;
    assign wdt_dec.period_log2 = `OBCL_PER_BASE_LOG2 + {2'b00, per_code};
    assign wdt_dec.slow_osc_lock = opt_r[`OBCL_IDX_WDT][`OBCL_WDT_LOCK];

    assign dbg_dec.debug_mode_force = opt_r[`OBCL_IDX_DBGM][`OBCL_DBGM_FORCE];
    assign dbg_dec.debug_stop_clock_cut = opt_r[`OBCL_IDX_DBGM][`OBCL_DBGM_CUT];
    assign dbg_dec.debug_ctrl = obcl_dbg_t'(dbg_code);
    // The prohibited code is treated as debug disabled for safety.
    assign dbg_dec.debug_enable = dbg_code[1];
    assign dbg_dec.erase_on_auth_fail = (dbg_code == 2'h3);

    // Programming mistakes are flagged, not corrected.
    assign bad_dec = opt_r[`OBCL_IDX_WDT][`OBCL_WDT_MUST_ZERO]
        || (per_code == `OBCL_PER_PROHIBIT && frac_code == `OBCL_FRAC_PROHIBIT)
        || (dbg_code == `OBCL_DBG_PROHIBIT);

    // Clock gating: the watchdog keeps its clock in run mode while the slow oscillator runs,
    // self-programming included, and in halt and stop only when the oscillator is locked on.
    assign gate_dec.slow_osc_enable = wdt_dec.slow_osc_lock
        || !run_state.slow_osc_stop_request;
    assign gate_dec.wdt_count_clk_en = wdt_dec.run_after_reset
        && (run_state.halt_or_stop ? wdt_dec.slow_osc_lock
            : gate_dec.slow_osc_enable);
    assign gate_dec.aux_timer_clk_en = run_state.aux_timer_on_slow_osc;
    assign gate_dec.internal_osc_keep = !(run_state.stop_mode && (!run_state.debug_active
        || dbg_dec.debug_stop_clock_cut));
    assign gate_dec.debug_serial_clk_en = run_state.debug_active
        && gate_dec.internal_osc_keep;

    // ------------------------------------------------------------------------
    // Registered outputs.
    // ------------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            wdt_cfg <= '0;
            detector_default_on <= 1'b0;
            dbg_cfg <= '0;
            clk_gate <= '0;
            cpu_reset_hold <= 1'b1;
            cfg_valid <= 1'b0;
            opt_bad <= 1'b0;
        end else begin
            wdt_cfg <= wdt_dec;
            detector_default_on <= opt_r[`OBCL_IDX_DET][`OBCL_DET_ON];
            dbg_cfg <= dbg_dec;
            clk_gate <= done ? gate_dec : '0;
            cpu_reset_hold <= !done;
            cfg_valid <= done;
            opt_bad <= done && bad_dec;
        end
    end

    // ------------------------------------------------------------------------
    // Register read port; the option bytes are read only, writes are ignored.
    // ------------------------------------------------------------------------
    logic [7:0] rd_sel;

    assign rd_sel = (reg_addr == `OBCL_REG_WDT) ? opt_r[`OBCL_IDX_WDT]
        : (reg_addr == `OBCL_REG_DET) ? opt_r[`OBCL_IDX_DET]
        : (reg_addr == `OBCL_REG_RSV) ? opt_r[`OBCL_IDX_RSV]
        : (reg_addr == `OBCL_REG_DBGM) ? opt_r[`OBCL_IDX_DBGM]
        : (reg_addr == `OBCL_REG_DBGS) ? opt_r[`OBCL_IDX_DBGS]
        : (reg_addr == `OBCL_REG_STATUS) ? {5'h00, swap_r, opt_bad, cfg_valid}
        : `OBCL_REG_RD_ZERO;

    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= `OBCL_REG_RD_ZERO;
        end else begin
            reg_rdata <= reg_rd ? rd_sel : `OBCL_REG_RD_ZERO;
        end
    end

    // ------------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------------
    sequence s_fetch_done;
        state_r == OBCL_ST_DONE;
    endsequence

    property p_hold_until_done;
        @(posedge clk) disable iff (rst)
        !done |=> cpu_reset_hold;
    endproperty
    a_hold_until_done: assert property (p_hold_until_done)
        else $error("processor released before fetch finished");

    property p_release_after_done;
        @(posedge clk) disable iff (rst)
        s_fetch_done |=> !cpu_reset_hold && cfg_valid;
    endproperty
    a_release_after_done: assert property (p_release_after_done)
        else $error("processor not released after fetch");

    property p_cfg_stable;
        @(posedge clk) disable iff (rst)
        cfg_valid && $past(cfg_valid) |-> $stable(wdt_cfg) && $stable(dbg_cfg);
    endproperty
    a_cfg_stable: assert property (p_cfg_stable)
        else $error("settings changed after load");

    property p_fetch_bound;
        @(posedge clk) $fell(rst) |-> ##[1:40] cfg_valid;
    endproperty
    a_fetch_bound: assert property (p_fetch_bound)
        else $error("fetch did not finish in time");

    property p_mirror_addr;
        @(posedge clk) disable iff (rst)
        flash_rd |-> flash_addr == (swap_r ? `OBCL_MIRROR_BASE : `OBCL_PRIMARY_BASE)
            + `OBCL_ADDR_W'(idx_r);
    endproperty
    a_mirror_addr: assert property (p_mirror_addr)
        else $error("option byte read from the wrong address");

    property p_wdt_gate;
        @(posedge clk) disable iff (rst)
        cfg_valid && $past(run_state.halt_or_stop) && !wdt_cfg.slow_osc_lock
            |-> !clk_gate.wdt_count_clk_en;
    endproperty
    a_wdt_gate: assert property (p_wdt_gate)
        else $error("watchdog clocked in halt without lock");

    property p_osc_lock;
        @(posedge clk) disable iff (rst)
        cfg_valid && wdt_cfg.slow_osc_lock |-> clk_gate.slow_osc_enable;
    endproperty
    a_osc_lock: assert property (p_osc_lock)
        else $error("locked slow oscillator stopped");

    property p_erase_decode;
        @(posedge clk) disable iff (rst)
        cfg_valid |-> dbg_cfg.erase_on_auth_fail == (dbg_cfg.debug_ctrl == OBCL_DBG_ERASE)
            && dbg_cfg.debug_enable == dbg_cfg.debug_ctrl[1];
    endproperty
    a_erase_decode: assert property (p_erase_decode)
        else $error("debug control decode wrong");

    property p_period;
        @(posedge clk) disable iff (rst)
        cfg_valid |-> wdt_cfg.period_log2 == 5'(wdt_cfg.period_sel) + 5'd10;
    endproperty
    a_period: assert property (p_period)
        else $error("overflow exponent wrong");

    property p_rd_pulse;
        @(posedge clk) disable iff (rst)
        flash_rd |=> !flash_rd;
    endproperty
    a_rd_pulse: assert property (p_rd_pulse)
        else $error("flash read strobe longer than one cycle");

    property p_quiet_after_done;
        @(posedge clk) disable iff (rst)
        s_fetch_done |-> !flash_rd;
    endproperty
    a_quiet_after_done: assert property (p_quiet_after_done)
        else $error("option area read after the load");

    property p_wdt_off;
        @(posedge clk) disable iff (rst)
        cfg_valid && !wdt_cfg.run_after_reset |-> !clk_gate.wdt_count_clk_en;
    endproperty
    a_wdt_off: assert property (p_wdt_off)
        else $error("watchdog clocked while disabled");

    property p_aux_clk;
        @(posedge clk) disable iff (rst)
        cfg_valid && $past(run_state.aux_timer_on_slow_osc) |-> clk_gate.aux_timer_clk_en;
    endproperty
    a_aux_clk: assert property (p_aux_clk)
        else $error("auxiliary timer clock withheld");

endmodule

// File: dv/obcl_flash_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Option flash area model with primary and mirror copies, one cycle latency.
// ----------------------------------------------------------------------------
module obcl_flash_model
    import obcl_pkg::*;
(
    input wire logic clk,
    input wire logic [15:0] flash_addr,
    input wire logic flash_rd,
    output logic [7:0] flash_rdata,
    input wire logic [39:0] prim_bytes,
    input wire logic [39:0] mirr_bytes
);
    logic [7:0] hit_byte;
    logic hit;

    // Both areas hold a full copy; the reader picks which one it uses.
    assign hit = flash_rd && (flash_addr[15:3] == 13'h0010 || flash_addr[15:3] == 13'h0210)
        && flash_addr[2:0] < 3'h5;
    assign hit_byte = flash_addr[12] ? mirr_bytes[flash_addr[2:0]*8 +: 8]
        : prim_bytes[flash_addr[2:0]*8 +: 8];

    // Outside the answer cycle the data lines show the inverse so a late sample fails.
    always_ff @(posedge clk) begin
        if (hit) begin
            flash_rdata <= hit_byte;
        end else begin
            flash_rdata <= ~hit_byte;
        end
    end
endmodule

// File: dv/obcl_loader_test.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
        fail_count++; \
        $display("Error at %0t: got %0h expected %0h", $time, got, exp); \
    end \
end

module obcl_loader_test
    import obcl_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic boot_swap = 1'b0;
    logic [15:0] flash_addr;
    logic flash_rd;
    logic [7:0] flash_rdata;
    obcl_run_state_t run_state = '0;
    obcl_wdt_cfg_t wdt_cfg;
    logic detector_default_on;
    obcl_dbg_cfg_t dbg_cfg;
    obcl_clk_gate_t clk_gate;
    logic cpu_reset_hold, cfg_valid, opt_bad;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [39:0] prim_bytes = '0;
    logic [39:0] mirr_bytes = '0;
    int fail_count = 0;
    int total_checks = 0;
    integer seed = 23781;
    logic [7:0] rd_q[$];
    logic [15:0] addr_q[$];
    logic rd_d = 1'b0;
    logic [7:0] exp_rd;
    logic [15:0] exp_addr;

    obcl_loader dut (.clk(clk), .rst(rst), .boot_swap(boot_swap), .flash_addr(flash_addr),
        .flash_rd(flash_rd), .flash_rdata(flash_rdata), .run_state(run_state),
        .wdt_cfg(wdt_cfg), .detector_default_on(detector_default_on), .dbg_cfg(dbg_cfg),
        .clk_gate(clk_gate), .cpu_reset_hold(cpu_reset_hold), .cfg_valid(cfg_valid),
        .opt_bad(opt_bad), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    obcl_flash_model flash (.clk(clk), .flash_addr(flash_addr), .flash_rd(flash_rd),
        .flash_rdata(flash_rdata), .prim_bytes(prim_bytes), .mirr_bytes(mirr_bytes));

    initial begin
        forever #2.5 clk = ~clk;
    end

    // ------------------------------------------------------------------------
    // Monitors: oldest expected note is compared when a result shows up.
    // ------------------------------------------------------------------------
    always @(posedge clk) begin
        rd_d <= reg_rd;
        if (rd_d) begin
            exp_rd = rd_q.pop_front();
            `CHK(reg_rdata, exp_rd)
        end else if (!rst) begin
            `CHK(reg_rdata, 8'h00)
        end
        if (flash_rd) begin
            exp_addr = addr_q.pop_front();
            `CHK(flash_addr, exp_addr)
        end
    end

    task automatic tally_and_finish();
        $display("Checks %0d, errors %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // One bus cycle; strobes stay as set until the next call or reg_idle.
    task automatic reg_op(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= wr;
        reg_rd <= ~wr;
        reg_addr <= a;
        reg_wdata <= d;
        if (!wr) begin
            rd_q.push_back(d);
        end
    endtask

    task automatic reg_idle();
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
    endtask

    // Legal option image for load i; loads 8, 9 and 10 each break one programming rule.
    function automatic logic [39:0] make_image(int i);
        logic [7:0] b0, b3, b4;
        int r;
        r = $random(seed);
        b0 = {1'b0, i[1:0] + 2'h1, r[0], i[2:0], r[1]};
        b3 = {3'b000, r[2], 3'b111, r[3]};
        b4 = {6'h00, (r[5:4] == 2'h0) ? 2'h0 : {1'b1, r[6]}};
        if (i == 8) b0[6:1] = {2'h0, r[0], 3'h0};
        if (i == 9) b4[1:0] = 2'h1;
        if (i == 10) b0[7] = 1'b1;
        return {b4, b3, 8'h00, {7'h00, r[7]}, b0};
    endfunction

    task automatic run_load(int i, int hold);
        logic [39:0] e;
        logic [7:0] b0, b3, b4;
        logic sw;
        logic [18:0] snap;
        obcl_run_state_t rs;
        int n;
        sw = $random(seed);
        prim_bytes <= make_image(i);
        mirr_bytes <= make_image((i < 8) ? (i + 3) % 8 : i);
        @(posedge clk);
        rst <= 1'b1;
        boot_swap <= sw;
        repeat (hold) @(posedge clk);
        e = sw ? mirr_bytes : prim_bytes;
        {b4, b3} = e[39:24];
        b0 = e[7:0];
        for (n = 0; n < 5; n++) addr_q.push_back((sw ? 16'h1080 : 16'h0080) + 16'(n));
        rst <= 1'b0;
        @(posedge clk);
        `CHK(cpu_reset_hold, 1'b1)
        for (n = 0; n < 40 && cfg_valid !== 1'b1; n++) @(posedge clk);
        `CHK(cfg_valid, 1'b1)
        `CHK(addr_q.size(), 0)
        @(posedge clk);
        `CHK(cpu_reset_hold, 1'b0)
        `CHK(wdt_cfg.open_fraction, b0[6:5])
        `CHK(wdt_cfg.run_after_reset, b0[4])
        `CHK(wdt_cfg.period_sel, b0[3:1])
        `CHK(wdt_cfg.period_log2, 5'h0a + {2'h0, b0[3:1]})
        `CHK(wdt_cfg.slow_osc_lock, b0[0])
        `CHK(detector_default_on, e[8])
        `CHK(dbg_cfg.debug_stop_clock_cut, b3[4])
        `CHK(dbg_cfg.debug_mode_force, b3[0])
        `CHK(dbg_cfg.debug_ctrl, b4[1:0])
        `CHK(dbg_cfg.debug_enable, b4[1])
        `CHK(dbg_cfg.erase_on_auth_fail, &b4[1:0])
        `CHK(opt_bad, i >= 8)
        for (n = 0; n < 5; n++) reg_op(1'b0, 8'h80 + 8'(n), e[n*8 +: 8]);
        reg_op(1'b1, 8'h80, ~b0);
        reg_op(1'b0, 8'h80, b0);
        reg_op(1'b0, 8'h85, 8'h00);
        reg_op(1'b0, 8'h90, {5'h00, sw, i >= 8, 1'b1});
        reg_idle();
        snap = {wdt_cfg, detector_default_on, dbg_cfg};
        boot_swap <= ~sw;
        prim_bytes <= ~prim_bytes;
        for (n = 0; n < 32; n++) begin
            rs = obcl_run_state_t'(n[4:0]);
            run_state <= rs;
            repeat (3) @(posedge clk);
            `CHK(clk_gate.slow_osc_enable, b0[0] | ~rs.slow_osc_stop_request)
            if (!rs.slow_osc_stop_request) begin
                `CHK(clk_gate.wdt_count_clk_en, b0[4] & (b0[0] | ~rs.halt_or_stop))
            end
            if (rs.aux_timer_on_slow_osc && rs.halt_or_stop && !rs.slow_osc_stop_request) begin
                `CHK(clk_gate.aux_timer_clk_en, 1'b1)
            end
            if (rs.stop_mode) begin
                `CHK(clk_gate.internal_osc_keep, rs.debug_active & ~b3[4])
            end
            if (rs.stop_mode && rs.debug_active) begin
                `CHK(clk_gate.debug_serial_clk_en, ~b3[4])
            end
        end
        `CHK({wdt_cfg, detector_default_on, dbg_cfg}, snap)
        run_state <= '0;
    endtask

    initial begin
        repeat (16) @(posedge clk);
        for (int i = 0; i < 11; i++) begin
            run_load(i, (i == 0) ? 1 : 2);
        end
        repeat (4) @(posedge clk);
        tally_and_finish();
    end

    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        tally_and_finish();
    end
endmodule
